// File: pkg/cbs_pkg.sv
package cbs_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] OUTPUT_SLEW_TRIM_ADDR  = 8'h4c; // slew trim register
   localparam logic [7:0] OUTPUT_SLEW_TRIM_RESET = 8'h66; // both codes at 6
   localparam logic [7:0] ENABLE_CTRL_LOW_ADDR   = 8'h01; // enables of outputs 0..5
   localparam logic [7:0] ENABLE_CTRL_HIGH_ADDR  = 8'h02; // enables of outputs 6..7
   localparam logic [7:0] ENABLE_READBACK_ADDR   = 8'h03; // enable pin levels
   localparam logic [7:0] OUTPUT_SETUP_ADDR      = 8'h08; // termination select
   localparam logic [7:0] ENABLE_CTRL_RESET      = 8'hff; // every enable bit set
   localparam logic [7:0] OUTPUT_SETUP_RESET     = 8'h00; // 85 ohm, low/low
   localparam logic [7:0] OUTPUT_SETUP_MASK      = 8'h3f; // bits 7:6 read zero
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int UPPER_CODE_LSB = 4;  // upper group code bits 7:4
   localparam int LOWER_CODE_LSB = 0;  // lower group code bits 3:0
   localparam int CODE_WIDTH     = 4;
   localparam int TERM_SEL_BIT   = 5;  // 0 = 85 ohm, 1 = 100 ohm
   localparam int PD_TRI_BIT     = 4;  // power-down state: 0 low/low, 1 tristate
   localparam int NUM_OUTPUTS    = 8;
   localparam int GROUP_SIZE     = 4;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       wr;    // one-cycle write strobe
      logic [7:0] addr;  // register address
      logic [7:0] wdata; // write data
   } cbs_req_s;

   typedef struct packed {
      logic [7:0] slew_trim;  // output_slew_trim
      logic [7:0] en_low;     // output_enable_ctrl_low
      logic [7:0] en_high;    // output_enable_ctrl_high
      logic [7:0] setup;      // termination and power-down style
      logic [7:0] rdata;      // registered read data
   } cbs_state_s;
endpackage

// File: rtl/cbs_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - slew trim register 0x4c, reset 0x66
// - bits 7:4 set upper group code
// - bits 3:0 set lower group code
// - outputs 0-3 lower, 4-7 upper group
// - code 0 least, f most capacitance
// - enable pins pulled down, float reads low
// - all register enable bits reset to one
// - default 85 ohm, alternative 100 ohm
// - enable bit zero disables, one enables only while its active-low pin reads low
module cbs_ctrl (
   input  wire logic             CORE_CLK_I,
   input  wire logic             RSTN_I,
   input  wire cbs_pkg::cbs_req_s REG_REQ_I,
   output logic      [7:0]       REG_RDATA_O,
   input  wire logic [7:0]       OE_N_I,
   input  wire logic [7:0]       OE_N_DRIVEN_I,
   output logic      [7:0]       CLK_OUT_EN_O,
   output logic      [7:0]       CLK_OUT_TRISTATE_O,
   output logic      [31:0]      SLEW_CODE_O,
   output logic                  TERM_100_OHM_O
);
   import cbs_pkg::*;

   // ------------------------------------------------------------
   // pin conditioning
   // ------------------------------------------------------------
   logic [15:0] sync_bus;  // drive flags above, pin levels below
   logic [7:0]  pin_sync;  // synchronised pin level, pulldown applied

   // pins are asynchronous: level and drive flag both pass two flops
   // before any gate sees them, so no logic sits ahead of the synchroniser
   cbs_sync #(
      .WIDTH (2 * NUM_OUTPUTS),
      .INIT  ('0)
   ) cbs_sync_inst (
      .CORE_CLK_I (CORE_CLK_I),
      .RSTN_I     (RSTN_I),
      .async_i    ({OE_N_DRIVEN_I, OE_N_I}),
      .sync_o     (sync_bus)
   );

   // an undriven pin reads low through its pulldown; a pin that starts
   // or stops being driven may show one stray cycle while both bits settle
   always_comb begin
      pin_sync = sync_bus[NUM_OUTPUTS +: NUM_OUTPUTS] & sync_bus[0 +: NUM_OUTPUTS];
   end

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   cbs_state_s state;      // all registered state
   cbs_state_s next_state; // its next value
   logic [7:0] reg_bit;    // flat view of per-output enable bits

   // write decode and read mux; reads return in the next cycle
   always_comb begin
      next_state = state;
      if (REG_REQ_I.wr) begin
         case (REG_REQ_I.addr)
            OUTPUT_SLEW_TRIM_ADDR: begin
               next_state.slew_trim = REG_REQ_I.wdata;
            end
            ENABLE_CTRL_LOW_ADDR: begin
               next_state.en_low = REG_REQ_I.wdata;
            end
            ENABLE_CTRL_HIGH_ADDR: begin
               next_state.en_high = REG_REQ_I.wdata;
            end
            OUTPUT_SETUP_ADDR: begin
               next_state.setup = REG_REQ_I.wdata & OUTPUT_SETUP_MASK;
            end
            default: begin
               // unmapped or read-only address: write ignored
            end
         endcase
      end
      // read data always tracks the addressed register
      case (REG_REQ_I.addr)
         OUTPUT_SLEW_TRIM_ADDR: next_state.rdata = state.slew_trim;
         ENABLE_CTRL_LOW_ADDR:  next_state.rdata = state.en_low;
         ENABLE_CTRL_HIGH_ADDR: next_state.rdata = state.en_high;
         ENABLE_READBACK_ADDR:  next_state.rdata = pin_sync;
         OUTPUT_SETUP_ADDR:     next_state.rdata = state.setup;
         default:               next_state.rdata = 8'h00;
      endcase
   end

   // register the whole state; reset values are constants
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state.slew_trim <= OUTPUT_SLEW_TRIM_RESET;
         state.en_low    <= ENABLE_CTRL_RESET;
         state.en_high   <= ENABLE_CTRL_RESET;
         state.setup     <= OUTPUT_SETUP_RESET;
         state.rdata     <= 8'h00;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // output gating
   // ------------------------------------------------------------
   // the enable bits are scattered around reserved bits:
   // low register holds outputs 0,1 at bits 1,2 and 2..5 at bits 4..7
   always_comb begin
      reg_bit = {state.en_high[2], state.en_high[0], state.en_low[7:4],
                 state.en_low[2:1]};
   end

   // clock drives only with bit set and active-low pin asserted
   always_comb begin
      CLK_OUT_EN_O = reg_bit & ~pin_sync;
   end

   // disabled outputs park per the power-down style bit
   always_comb begin
      CLK_OUT_TRISTATE_O = ~CLK_OUT_EN_O & {NUM_OUTPUTS{state.setup[PD_TRI_BIT]}};
   end

   // each group shares one code; 0 least cap, f most, linear steps
   genvar g;
   generate
      for (g = 0; g < NUM_OUTPUTS; g++) begin : g_code
         if (g < GROUP_SIZE) begin : g_low
            assign SLEW_CODE_O[g*CODE_WIDTH +: CODE_WIDTH] =
               state.slew_trim[LOWER_CODE_LSB +: CODE_WIDTH];
         end else begin : g_high
            assign SLEW_CODE_O[g*CODE_WIDTH +: CODE_WIDTH] =
               state.slew_trim[UPPER_CODE_LSB +: CODE_WIDTH];
         end
      end
   endgenerate

   // termination: 0 keeps 85 ohm, 1 selects 100 ohm
   assign TERM_100_OHM_O = state.setup[TERM_SEL_BIT];
   assign REG_RDATA_O    = state.rdata;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   trim_write_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      REG_REQ_I.wr && REG_REQ_I.addr == OUTPUT_SLEW_TRIM_ADDR |=>
      SLEW_CODE_O[31:28] == $past(REG_REQ_I.wdata[7:4]) &&
      SLEW_CODE_O[3:0] == $past(REG_REQ_I.wdata[3:0]))
      else $error("trim write not applied");
   // a read returns the trim as it stood before any write in that cycle
   trim_read_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      REG_REQ_I.addr == OUTPUT_SLEW_TRIM_ADDR |=>
      REG_RDATA_O == {$past(SLEW_CODE_O[31:28]), $past(SLEW_CODE_O[3:0])})
      else $error("trim readback wrong");
   upper_group_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      SLEW_CODE_O[19:16] == state.slew_trim[7:4] && SLEW_CODE_O[31:28] == SLEW_CODE_O[19:16])
      else $error("upper group code wrong");
   lower_group_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      SLEW_CODE_O[15:12] == state.slew_trim[3:0] && SLEW_CODE_O[3:0] == SLEW_CODE_O[15:12])
      else $error("lower group code wrong");
   trim_hold_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      !(REG_REQ_I.wr && REG_REQ_I.addr == OUTPUT_SLEW_TRIM_ADDR) |=> $stable(SLEW_CODE_O))
      else $error("trim changed without write");
   float_low_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      OE_N_DRIVEN_I == 8'h00 [*3] |-> pin_sync == 8'h00)
      else $error("floating pin not low");
   bit_off_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      REG_REQ_I.wr && REG_REQ_I.addr == ENABLE_CTRL_LOW_ADDR && !REG_REQ_I.wdata[1]
      |=> !CLK_OUT_EN_O[0])
      else $error("disabled output driven");
   upper_off_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      REG_REQ_I.wr && REG_REQ_I.addr == ENABLE_CTRL_HIGH_ADDR && !REG_REQ_I.wdata[0]
      |=> !CLK_OUT_EN_O[6])
      else $error("disabled upper output driven");
   gate_and_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      CLK_OUT_EN_O[7] == (state.en_high[2] && !pin_sync[7]))
      else $error("output gate mismatch");
   // a pin held high and driven for three cycles has reached the gate
   pin_block_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      (OE_N_I[3] && OE_N_DRIVEN_I[3]) [*3] |-> !CLK_OUT_EN_O[3])
      else $error("deasserted pin not obeyed");
   // a driven output is never parked, a parked style covers every idle one
   drive_park_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      (CLK_OUT_EN_O & CLK_OUT_TRISTATE_O) == 8'h00)
      else $error("driven output also tristated");
   park_all_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      state.setup[PD_TRI_BIT] |-> (CLK_OUT_EN_O | CLK_OUT_TRISTATE_O) == 8'hff)
      else $error("disabled output not tristated");
   term_sel_a : assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
      REG_REQ_I.wr && REG_REQ_I.addr == OUTPUT_SETUP_ADDR |=>
      TERM_100_OHM_O == $past(REG_REQ_I.wdata[TERM_SEL_BIT]))
      else $error("termination select wrong");
endmodule

// File: rtl/cbs_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a bus of pin levels
module cbs_sync #(
   parameter int           WIDTH = 8,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             CORE_CLK_I,
   input  wire logic             RSTN_I,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] meta; // first stage, read only by second
      logic [WIDTH-1:0] sync; // second stage
   } cbs_sync_s;

   cbs_sync_s state;
   cbs_sync_s next_state;

   // shift one stage per clock
   always_comb begin
      next_state.meta = async_i;
      next_state.sync = state.meta;
   end

   // constant reset, no port value taken under reset
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state <= {INIT, INIT};
      end else begin
         state <= next_state;
      end
   end

   assign sync_o = state.sync;
endmodule

// File: verification/cbs_ctrl_tb.sv
`timescale 1ns/100ps
module cbs_ctrl_tb;
   import cbs_pkg::*;
   // ------------------------------------------------------------
   // signals and scoreboard
   // ------------------------------------------------------------
   typedef struct {string nm; logic [31:0] exp; int sel;} cbs_note_s;
   logic        clk, rstn, term;
   cbs_req_s    req;
   logic [7:0]  rdata, lvl, drv, oe_n, oe_drv, en, lo, hi, v, park, ex_en;
   logic [31:0] slew;
   logic [31:0] seed = 32'h1d;            // xorshift seed 29
   int          err_count = 0;
   int          n_checks = 0;
   cbs_note_s   notes[$];                 // expected results, oldest first
   cbs_pin_model cbs_pin_model_inst (.level_i(lvl), .drive_i(drv), .pin_o(oe_n),
      .driven_o(oe_drv));
   cbs_ctrl cbs_ctrl_inst (.CORE_CLK_I(clk), .RSTN_I(rstn), .REG_REQ_I(req),
      .REG_RDATA_O(rdata), .OE_N_I(oe_n), .OE_N_DRIVEN_I(oe_drv), .CLK_OUT_EN_O(en),
      .CLK_OUT_TRISTATE_O(park), .SLEW_CODE_O(slew), .TERM_100_OHM_O(term));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // note an expectation for the watcher
   task automatic note(string nm, logic [31:0] exp, int sel);
      notes.push_back('{nm, exp, sel});
   endtask
   // one-cycle write strobe, outputs settled on return
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk) #1 req = '{1'b1, a, d};
      @(posedge clk) #1 req.wr = 1'b0;
   endtask
   // registered read: data one edge after address
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      @(posedge clk) #1 req.addr = a;
      @(posedge clk) #1 note("rdata", {24'h0, exp}, 0);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // watcher: oldest note against the output it names
   // ------------------------------------------------------------
   initial begin : watch
      cbs_note_s   n;
      logic [31:0] got;
      // drained at the falling edge, where every noted output is settled;
      // several notes taken in one step are all compared there
      forever begin
         @(negedge clk);
         while (notes.size() > 0) begin
            n = notes.pop_front();
            got = (n.sel == 0) ? {24'h0, rdata} : (n.sel == 1) ? slew :
                  (n.sel == 2) ? {24'h0, en} :
                  (n.sel == 3) ? {31'h0, term} : {24'h0, park};
            n_checks++;
            if (got !== n.exp) begin
               err_count++;
               $display("[ERR] %s expected %h seen %h", n.nm, n.exp, got);
            end
         end
      end
   end
   // ------------------------------------------------------------
   // clock, watchdog, main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // a hang counts as a mismatch
   initial begin
      #200000;
      err_count++;
      final_report();
   end
   initial begin
      rstn = 1'b0;
      req  = '0;
      lvl  = 8'h00;
      drv  = 8'h00;                        // pins left floating
      repeat (8) @(posedge clk);
      #1 rstn = 1'b1;
      note("en", 32'hff, 2);
      note("slew", 32'h66666666, 1);
      note("term", 32'h0, 3);
      rd(OUTPUT_SLEW_TRIM_ADDR, OUTPUT_SLEW_TRIM_RESET);
      // both code extremes first, then random codes
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
         wr(OUTPUT_SLEW_TRIM_ADDR, v);
         note("slew", {{4{v[7:4]}}, {4{v[3:0]}}}, 1);
         rd(OUTPUT_SLEW_TRIM_ADDR, v);
      end
      // all bits cleared first, then random bits against random pins
      for (int i = 0; i < 8; i++) begin
         lo  = (i == 0) ? 8'h00 : rnd();
         hi  = (i == 0) ? 8'h00 : rnd();
         lvl = rnd();
         drv = rnd();
         wr(ENABLE_CTRL_LOW_ADDR, lo);
         wr(ENABLE_CTRL_HIGH_ADDR, hi);
         ex_en = {hi[2], hi[0], lo[7:4], lo[2:1]} & ~(lvl & drv);
         note("en", {24'h0, ex_en}, 2);
         rd(ENABLE_READBACK_ADDR, lvl & drv);
         rd(ENABLE_CTRL_HIGH_ADDR, hi);
      end
      // tristate parking with 100 ohm, then reserved bits refused
      wr(OUTPUT_SETUP_ADDR, 8'h30);
      note("term", 32'h1, 3);
      note("park", {24'h0, ~ex_en}, 4);
      rd(OUTPUT_SETUP_ADDR, 8'h30);
      wr(OUTPUT_SETUP_ADDR, 8'hc0);
      note("term", 32'h0, 3);
      note("park", 32'h0, 4);
      rd(OUTPUT_SETUP_ADDR, 8'h00);
      // second reset mid-run with pins released: defaults come back
      lvl = 8'h00;
      drv = 8'h00;
      @(posedge clk) #1 rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      note("en", 32'hff, 2);
      note("slew", 32'h66666666, 1);
      rd(ENABLE_CTRL_LOW_ADDR, ENABLE_CTRL_RESET);
      // let the watcher drain the last notes first
      @(negedge clk);
      #1 final_report();
   end
endmodule

// File: verification/cbs_pin_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// enable pin drivers, gpio side
// ------------------------------------------------------------
module cbs_pin_model (
   input  wire logic [7:0] level_i,  // level a driven pin carries
   input  wire logic [7:0] drive_i,  // 1 = gpio drives pin n
   output logic      [7:0] pin_o,    // wire level at the pins
   output logic      [7:0] driven_o  // drive flags seen by the block
);
   // a released pin falls to its pulldown, never keeps its last level
   assign pin_o    = level_i & drive_i;
   assign driven_o = drive_i;
endmodule
